// >>> host_control_pkg.sv
// constants for the host operating control register block
package host_control_pkg;
    localparam logic [7:0]  CTRL_OFFSET        = 8'h04;
    localparam int          WAKE_ENABLE_BIT    = 10;
    localparam int          WAKE_CONNECTED_BIT = 9;
    localparam int          IRQ_ROUTING_BIT    = 8;
    localparam int          STATE_MSB          = 7;
    localparam int          STATE_LSB          = 6;
    localparam int          BULK_ENABLE_BIT    = 5;
    localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
    localparam logic [31:0] CTRL_WRITE_MASK    = 32'h0000_07e0;
    localparam int          CLK_HZ             = 25000000;
    localparam int          SOF_DELAY_US       = 1000;
    localparam int          SOF_DELAY_CYCLES   = (CLK_HZ / 1000000) * SOF_DELAY_US;

    typedef enum logic [1:0] {
        state_reset       = 2'b00,
        state_resume      = 2'b01,
        state_operational = 2'b10,
        state_suspend     = 2'b11
    } functional_state_type;
endpackage

// >>> sof_delay_timer.sv
// one-shot delay from entry into operational to first frame start
`timescale 1ns/100ps
module sof_delay_timer #(
    parameter int DELAY_CYCLES = 25000
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic cancel,
    output logic      expired
);
    logic [31:0] count;
    logic        running;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 32'h0000_0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (cancel) begin
                running <= 1'b0;
            end else if (start) begin
                count   <= 32'h0000_0001;
                running <= 1'b1;
            end else if (running) begin
                if (count >= DELAY_CYCLES[31:0]) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count <= count + 32'h0000_0001;
                end
            end
        end
    end
endmodule

// >>> host_operating_control.sv
// host operating control register with functional state and frame start timing
`timescale 1ns/100ps
module host_operating_control #(
    parameter int SOF_DELAY = host_control_pkg::SOF_DELAY_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        soft_reset,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        resume_detected_status,
    input  wire logic        irq_pending,
    input  wire logic        downstream_resume,
    input  wire logic        frame_boundary,
    input  wire logic        bulk_request,
    output logic             remote_wake,
    output logic             host_irq,
    output logic             mgmt_irq,
    output logic             frame_start_flag,
    output logic             frame_gen_active,
    output logic             root_hub_reset,
    output logic             port_reset,
    output logic             bulk_grant,
    output logic [1:0]       functional_state
);
    logic                                   wake_enable;
    logic                                   wake_connected;
    logic                                   irq_routing;
    logic                                   bulk_list_enable;
    logic                                   bulk_frame_enable;
    host_control_pkg::functional_state_type fstate;
    host_control_pkg::functional_state_type prev_state;
    logic                                   resume_sync1;
    logic                                   resume_sync2;
    logic                                   hw_reset_seq;
    logic                                   sof_expired;
    logic                                   sof_start;
    logic                                   sof_cancel;
    logic                                   ctrl_write;

    assign ctrl_write = reg_write && (reg_addr == host_control_pkg::CTRL_OFFSET);
    assign sof_start  = (fstate == host_control_pkg::state_operational)
                        && (prev_state != host_control_pkg::state_operational);
    assign sof_cancel = (fstate != host_control_pkg::state_operational) || soft_reset;

    // pin from downstream port, two-flop synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_sync1 <= 1'b0;
            resume_sync2 <= 1'b0;
        end else begin
            resume_sync1 <= downstream_resume;
            resume_sync2 <= resume_sync1;
        end
    end

    // driver-owned bits, hardware reset clears, software reset keeps
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_enable      <= 1'b0;
            wake_connected   <= 1'b0;
            irq_routing      <= 1'b0;
            bulk_list_enable <= 1'b0;
        end else if (ctrl_write) begin
            wake_enable      <= reg_wdata[host_control_pkg::WAKE_ENABLE_BIT];
            wake_connected   <= reg_wdata[host_control_pkg::WAKE_CONNECTED_BIT];
            irq_routing      <= reg_wdata[host_control_pkg::IRQ_ROUTING_BIT];
            bulk_list_enable <= reg_wdata[host_control_pkg::BULK_ENABLE_BIT];
        end
    end

    // functional state: software reset wins, then driver write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fstate <= host_control_pkg::state_reset;
        end else if (soft_reset) begin
            fstate <= host_control_pkg::state_suspend;
        end else if (ctrl_write) begin
            fstate <= host_control_pkg::functional_state_type'(
                reg_wdata[host_control_pkg::STATE_MSB:host_control_pkg::STATE_LSB]);
        end else begin
            case (fstate)
                host_control_pkg::state_suspend: begin
                    if (resume_sync2) begin
                        fstate <= host_control_pkg::state_resume;
                    end
                end
                default: begin
                    fstate <= fstate;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_state <= host_control_pkg::state_reset;
        end else begin
            prev_state <= fstate;
        end
    end

    // root hub reset follows hardware reset only; port reset asserts after hardware reset until driver leaves reset state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_reset_seq   <= 1'b1;
            root_hub_reset <= 1'b1;
            port_reset     <= 1'b0;
        end else begin
            if (fstate != host_control_pkg::state_reset) begin
                hw_reset_seq <= 1'b0;
            end
            root_hub_reset <= 1'b0;
            port_reset     <= hw_reset_seq && (fstate == host_control_pkg::state_reset);
        end
    end

    // 1 ms hold-off before first frame start
    sof_delay_timer #(
        .DELAY_CYCLES (SOF_DELAY)
    ) u_sof_delay (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (sof_start),
        .cancel   (sof_cancel),
        .expired  (sof_expired)
    );

    // flag frame start once generation begins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_gen_active <= 1'b0;
            frame_start_flag <= 1'b0;
        end else begin
            if (sof_cancel) begin
                frame_gen_active <= 1'b0;
            end else if (sof_expired) begin
                frame_gen_active <= 1'b1;
            end
            frame_start_flag <= sof_expired || (frame_gen_active && frame_boundary);
        end
    end

    // bulk enable latched per frame, clearing it stops grants at once; sampled on each request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bulk_frame_enable <= 1'b0;
            bulk_grant        <= 1'b0;
        end else begin
            if (frame_boundary) begin
                bulk_frame_enable <= bulk_list_enable;
            end
            bulk_grant <= bulk_request && bulk_frame_enable && bulk_list_enable
                          && frame_gen_active;
        end
    end

    // wake independent of routing; routing picks irq line
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_wake <= 1'b0;
            host_irq    <= 1'b0;
            mgmt_irq    <= 1'b0;
        end else begin
            remote_wake <= wake_enable && resume_detected_status;
            host_irq    <= irq_pending && !irq_routing;
            mgmt_irq    <= irq_pending && irq_routing;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata        <= host_control_pkg::CTRL_RESET;
            functional_state <= 2'b00;
        end else begin
            functional_state <= fstate;
            reg_rdata        <= 32'h0000_0000;
            if (reg_read && (reg_addr == host_control_pkg::CTRL_OFFSET)) begin
                reg_rdata <= {21'h000000, wake_enable, wake_connected, irq_routing,
                              fstate, bulk_list_enable, 5'h00}
                             & host_control_pkg::CTRL_WRITE_MASK;
            end
        end
    end

    wake_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wake_enable && resume_detected_status) |=> remote_wake)
        else $error("remote wake not raised");
    // wake enable does not gate interrupts
    irq_free_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq_pending && !irq_routing) |=> host_irq)
        else $error("host irq missing");
    route_mgmt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq_pending && irq_routing) |=> (mgmt_irq && !host_irq))
        else $error("irq misrouted");
    route_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (soft_reset && !ctrl_write) |=> $stable(irq_routing) && $stable(wake_connected))
        else $error("routing changed by soft reset");
    soft_suspend_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        soft_reset |=> fstate == host_control_pkg::state_suspend)
        else $error("soft reset not suspend");
    state_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!soft_reset && !ctrl_write && fstate != host_control_pkg::state_suspend)
        |=> $stable(fstate))
        else $error("state changed by device");
    sequence resume_seen_s;
        fstate == host_control_pkg::state_suspend && resume_sync2
            && !soft_reset && !ctrl_write;
    endsequence
    resume_move_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        resume_seen_s |=> fstate == host_control_pkg::state_resume)
        else $error("resume not entered");
    sof_early_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sof_start |=> (!frame_gen_active) [*8])
        else $error("frame start too early");
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rdata[31:11] == 21'h000000)
        else $error("reserved bits nonzero");
endmodule

// >>> ohci_host_control_modes_tb_top.sv
// self-checking bench for the host operating control register block
`timescale 1ns/100ps
module ohci_host_control_modes_tb_top;
    localparam int SOF_DLY = 20;
    logic        core_clk               = 1'b0;
    logic        rst_n                  = 1'b0;
    logic        soft_reset             = 1'b0;
    logic        reg_write              = 1'b0;
    logic        reg_read               = 1'b0;
    logic [7:0]  reg_addr               = 8'h00;
    logic [31:0] reg_wdata              = 32'h0000_0000;
    logic        resume_detected_status = 1'b0;
    logic        irq_pending            = 1'b0;
    logic        downstream_resume      = 1'b0;
    logic        frame_boundary         = 1'b0;
    logic        bulk_request           = 1'b0;
    logic        rd_seen                = 1'b0;
    logic [31:0] reg_rdata;
    logic        remote_wake;
    logic        host_irq;
    logic        mgmt_irq;
    logic        frame_start_flag;
    logic        frame_gen_active;
    logic        root_hub_reset;
    logic        port_reset;
    logic        bulk_grant;
    logic [1:0]  functional_state;
    logic [31:0] exp_q[$];
    logic [31:0] r;
    int          miscompares = 0;
    int          checked     = 0;
    int          sof_cnt     = 0;
    int          sof_base    = 0;
    int          seed        = 32'hcf43;
    int          n;

    always #20 core_clk = ~core_clk;

    host_operating_control #(.SOF_DELAY(SOF_DLY)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .resume_detected_status(resume_detected_status), .irq_pending(irq_pending),
        .downstream_resume(downstream_resume), .frame_boundary(frame_boundary),
        .bulk_request(bulk_request), .remote_wake(remote_wake), .host_irq(host_irq),
        .mgmt_irq(mgmt_irq), .frame_start_flag(frame_start_flag),
        .frame_gen_active(frame_gen_active), .root_hub_reset(root_hub_reset),
        .port_reset(port_reset), .bulk_grant(bulk_grant),
        .functional_state(functional_state)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    // strobe dropped a full edge before the next request may raise it
    task automatic wr(input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr  <= 8'h04;
        reg_wdata <= d;
        tick(1);
        reg_write <= 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        reg_read <= 1'b1;
        reg_addr <= a;
        tick(1);
        reg_read <= 1'b0;
        tick(1);
    endtask

    always @(posedge core_clk) rd_seen <= reg_read;

    // read data stands for one cycle from the taking edge; checked at the falling edge in between
    always @(negedge core_clk) begin
        if (frame_start_flag === 1'b1)
            sof_cnt++;
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0)
                check("read queue", 32'h1, 32'h0);
            else
                check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (2) @(negedge core_clk);
        check("root_hub_reset in reset", root_hub_reset, 32'h1);
        check("state in reset", functional_state, 32'h0);
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        rd(8'h04, 32'h0000_0000);
        @(negedge core_clk);
        check("port_reset", port_reset, 32'h1);
        check("root_hub_reset", root_hub_reset, 32'h0);
        @(posedge core_clk);
        $display("test reset_values done");
        wr(32'hffff_ffff);
        rd(8'h04, 32'h0000_07e0);
        rd(8'h08, 32'h0000_0000);
        $display("test reserved_bits done");
        for (n = 0; n < 8; n++) begin
            r = $random(seed);
            wr({21'h0, r[2], 1'b0, r[1], 2'b11, 6'h0});
            resume_detected_status <= r[3];
            irq_pending            <= r[4];
            tick(3);
            @(negedge core_clk);
            check("remote_wake", remote_wake, r[2] & r[3]);
            check("host_irq", host_irq, r[4] & ~r[1]);
            check("mgmt_irq", mgmt_irq, r[4] & r[1]);
            @(posedge core_clk);
        end
        $display("test wake_and_routing done");
        wr(32'h0000_07a0);
        soft_reset <= 1'b1;
        tick(1);
        soft_reset <= 1'b0;
        tick(1);
        rd(8'h04, 32'h0000_07e0);
        downstream_resume <= 1'b1;
        tick(6);
        downstream_resume <= 1'b0;
        tick(1);
        rd(8'h04, 32'h0000_0760);
        $display("test soft_reset_resume done");
        // counter owned by the watcher, so take a baseline instead of clearing it
        sof_base = sof_cnt;
        wr(32'h0000_00a0);
        for (n = 0; n <= SOF_DLY + 10 && frame_gen_active !== 1'b1; n++)
            @(negedge core_clk);
        // used-up limit counts as a mismatch; the verdict still comes at the end
        if (n > SOF_DLY + 10) begin
            miscompares++;
        end
        check("frame start not early", n >= SOF_DLY - 2, 32'h1);
        check("frame start not late", n <= SOF_DLY + 4, 32'h1);
        tick(3);
        check("frame start flag pulses", sof_cnt - sof_base, 32'h1);
        downstream_resume <= 1'b1;
        tick(6);
        downstream_resume <= 1'b0;
        @(negedge core_clk);
        check("state kept operational", functional_state, 32'h2);
        @(posedge core_clk);
        $display("test frame_start done");
        bulk_request   <= 1'b1;
        frame_boundary <= 1'b1;
        tick(1);
        frame_boundary <= 1'b0;
        tick(3);
        @(negedge core_clk);
        check("bulk_grant enabled", bulk_grant, 32'h1);
        @(posedge core_clk);
        wr(32'h0000_0080);
        tick(2);
        @(negedge core_clk);
        check("bulk_grant cleared", bulk_grant, 32'h0);
        @(posedge core_clk);
        frame_boundary <= 1'b1;
        tick(1);
        frame_boundary <= 1'b0;
        tick(1);
        wr(32'h0000_00a0);
        tick(2);
        @(negedge core_clk);
        check("bulk_grant before frame", bulk_grant, 32'h0);
        @(posedge core_clk);
        frame_boundary <= 1'b1;
        tick(1);
        frame_boundary <= 1'b0;
        tick(3);
        @(negedge core_clk);
        check("bulk_grant next frame", bulk_grant, 32'h1);
        @(posedge core_clk);
        $display("test bulk_enable done");
        rst_n <= 1'b0;
        tick(2);
        @(negedge core_clk);
        check("root_hub_reset again", root_hub_reset, 32'h1);
        check("frames stopped", frame_gen_active, 32'h0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        rd(8'h04, 32'h0000_0000);
        @(negedge core_clk);
        check("port_reset again", port_reset, 32'h1);
        $display("test mid_run_reset done");
        tick(2);
        check("read queue drained", exp_q.size(), 32'h0);
        finish_test();
    end
endmodule
